// file: design/capture_recorder.sv
// dual-channel event capture recorder with register port and flash backup
`default_nettype none
// Functional notes
// - only armed alarms start a capture
// - alarm source independent of recorded sources
// - setup 15:12 buffer two, 11:8 one
// - source codes 1,2,3,4,5,8 decoded
// - setup 7:4 pretrigger count power two
// - pretrigger above length truncates to length
// - setup 3:0 length power two, 3..10
// - misc bit 11 enables flash backup
// - full buffer copied to flash
// - saved capture restored at every reset
// - command 0x03 erases sram and flash
// - finished capture presents first sample
// - index advances after each readout read
// - index readable and writable by host
// - index bits 10:0, value 1..1024
// - word bit 14 alarm, 13:0 data
// - alarm control bits 6,4 arm triggers
// - alarm control 15:12,11:8 select monitored source
// - threshold bit 15 direction, 13:0 level
module capture_recorder (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic SAMPLE_TICK,
    input wire logic [13:0] SUPPLY_DATA,
    input wire logic [13:0] XACC_DATA,
    input wire logic [13:0] YACC_DATA,
    input wire logic [13:0] AUX_DATA,
    input wire logic [13:0] TEMP_DATA,
    input wire logic [13:0] RSS_DATA,
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    output logic [10:0] FLASH_ADDR,
    output logic [31:0] FLASH_WDATA,
    output logic FLASH_WR,
    output logic FLASH_RD,
    output logic FLASH_ERASE,
    input wire logic [31:0] FLASH_RDATA,
    input wire logic FLASH_BUSY,
    output logic CAPTURE_DONE
);
    typedef struct packed {
        capture_pkg::state_type st;
        logic [15:0] setup;
        logic [15:0] alarm_ctl;
        logic [15:0] thr1;
        logic [15:0] thr2;
        logic [15:0] misc;
        logic [10:0] index;
        logic [9:0] ring_pos;
        logic [9:0] ring_start;
        logic ring_full;
        logic [10:0] count;
        logic [3:0] len_e;
        logic [3:0] pre_e;
        logic done;
        logic clr_req;
        logic [10:0] walk;
        logic pend;
        logic [15:0] rdata;
        logic rvalid;
        logic [10:0] f_addr;
        logic [31:0] f_wdata;
        logic f_wr;
        logic f_rd;
        logic f_erase;
    } regs_type;

    regs_type r, n;
    logic [14:0] mem1 [0:1023];
    logic [14:0] mem2 [0:1023];
    logic mem_we, fin, set_clr, armed_en, trig, a1, a2, any_alarm;
    logic v1, v2, va1, va2;
    logic [9:0] mem_addr, rd_phys;
    logic [14:0] mem_d1, mem_d2, cap1, cap2;
    logic [13:0] d1, d2, da1, da2;
    logic [10:0] pre_n, len_n, idx_next;
    logic [3:0] len_sel, pre_sel;
    logic [15:0] idx_merged;

    source_mux u_src_one (
        .code(r.setup[capture_pkg::SRC_ONE_LSB +: 4]),
        .supply(SUPPLY_DATA), .xacc(XACC_DATA), .yacc(YACC_DATA),
        .aux(AUX_DATA), .temp(TEMP_DATA), .rss(RSS_DATA),
        .data(d1), .valid(v1)
    );
    source_mux u_src_two (
        .code(r.setup[capture_pkg::SRC_TWO_LSB +: 4]),
        .supply(SUPPLY_DATA), .xacc(XACC_DATA), .yacc(YACC_DATA),
        .aux(AUX_DATA), .temp(TEMP_DATA), .rss(RSS_DATA),
        .data(d2), .valid(v2)
    );
    // alarm sources are muxed separately from the recorded ones
    source_mux u_src_alm_one (
        .code(r.alarm_ctl[11:8]),
        .supply(SUPPLY_DATA), .xacc(XACC_DATA), .yacc(YACC_DATA),
        .aux(AUX_DATA), .temp(TEMP_DATA), .rss(RSS_DATA),
        .data(da1), .valid(va1)
    );
    source_mux u_src_alm_two (
        .code(r.alarm_ctl[15:12]),
        .supply(SUPPLY_DATA), .xacc(XACC_DATA), .yacc(YACC_DATA),
        .aux(AUX_DATA), .temp(TEMP_DATA), .rss(RSS_DATA),
        .data(da2), .valid(va2)
    );
    alarm_unit u_alm_one (.data(da1), .valid(va1), .threshold(r.thr1), .hit(a1));
    alarm_unit u_alm_two (.data(da2), .valid(va2), .threshold(r.thr2), .hit(a2));

    assign any_alarm = a1 | a2;
    assign armed_en = r.alarm_ctl[capture_pkg::TRIG_ONE_BIT]
                    | r.alarm_ctl[capture_pkg::TRIG_TWO_BIT];
    assign trig = (a1 & r.alarm_ctl[capture_pkg::TRIG_ONE_BIT])
                | (a2 & r.alarm_ctl[capture_pkg::TRIG_TWO_BIT]);
    // unselected source records zeros in bits 13:0
    assign cap1 = {any_alarm, v1 ? d1 : 14'h0000};
    assign cap2 = {any_alarm, v2 ? d2 : 14'h0000};
    assign pre_n = 11'h001 << r.pre_e;
    assign len_n = 11'h001 << r.len_e;
    // lengths outside 3..10 are clamped rather than refused
    assign len_sel = (r.setup[3:0] < capture_pkg::LEN_MIN) ? capture_pkg::LEN_MIN :
                     (r.setup[3:0] > capture_pkg::LEN_MAX) ? capture_pkg::LEN_MAX :
                     r.setup[3:0];
    assign pre_sel = (r.setup[7:4] > len_sel) ? len_sel : r.setup[7:4];
    // sample n sits in the ring (rotated) if it is pretrigger, else in place
    always_comb begin
        logic [9:0] lg;
        lg = r.index[9:0] - 10'h001;
        if ({1'b0, lg} < pre_n) begin
            rd_phys = (lg + r.ring_start) & (pre_n[9:0] - 10'h001);
        end else begin
            rd_phys = lg;
        end
    end
    assign idx_next = (r.index >= capture_pkg::INDEX_LAST) ? capture_pkg::INDEX_FIRST :
                      r.index + 11'h001;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic hi,
                                          input logic [7:0] b);
        merge = hi ? {b, old[7:0]} : {old[15:8], b};
    endfunction
    // a function result cannot be part-selected, so the merged index is a net of its own
    assign idx_merged = merge({5'h00, r.index}, REG_ADDR[0], REG_WDATA);

    always_comb begin
        n = r;
        n.rvalid = 1'b0;
        n.f_wr = 1'b0;
        n.f_rd = 1'b0;
        n.f_erase = 1'b0;
        mem_we = 1'b0;
        mem_addr = r.walk[9:0];
        mem_d1 = cap1;
        mem_d2 = cap2;
        fin = 1'b0;
        set_clr = 1'b0;
        if (REG_WR) begin
            case ({REG_ADDR[6:1], 1'b0})
                capture_pkg::ADDR_SETUP: n.setup = merge(r.setup, REG_ADDR[0], REG_WDATA);
                capture_pkg::ADDR_ALARM_CTRL:
                    n.alarm_ctl = merge(r.alarm_ctl, REG_ADDR[0], REG_WDATA);
                capture_pkg::ADDR_THR_ONE: n.thr1 = merge(r.thr1, REG_ADDR[0], REG_WDATA);
                capture_pkg::ADDR_THR_TWO: n.thr2 = merge(r.thr2, REG_ADDR[0], REG_WDATA);
                capture_pkg::ADDR_MISC: n.misc = merge(r.misc, REG_ADDR[0], REG_WDATA);
                capture_pkg::ADDR_INDEX: begin
                    n.index = idx_merged[10:0];
                end
                capture_pkg::ADDR_COMMAND: begin
                    set_clr = !REG_ADDR[0] && REG_WDATA == capture_pkg::CMD_CLEAR;
                end
                default: ;
            endcase
        end else if (REG_RD) begin
            n.rvalid = 1'b1;
            case ({REG_ADDR[6:1], 1'b0})
                capture_pkg::ADDR_SETUP: n.rdata = r.setup;
                capture_pkg::ADDR_ALARM_CTRL: n.rdata = r.alarm_ctl;
                capture_pkg::ADDR_THR_ONE: n.rdata = r.thr1;
                capture_pkg::ADDR_THR_TWO: n.rdata = r.thr2;
                capture_pkg::ADDR_MISC: n.rdata = r.misc;
                capture_pkg::ADDR_INDEX: n.rdata = {5'h00, r.index};
                capture_pkg::ADDR_READOUT_ONE: begin
                    n.rdata = {1'b0, mem1[rd_phys]};
                    n.index = idx_next;
                end
                capture_pkg::ADDR_READOUT_TWO: begin
                    n.rdata = {1'b0, mem2[rd_phys]};
                    n.index = idx_next;
                end
                default: n.rdata = 16'h0000;
            endcase
        end
        if (set_clr) begin
            n.clr_req = 1'b1;
        end
        case (r.st)
            capture_pkg::ST_IDLE, capture_pkg::ST_ARMED, capture_pkg::ST_POST: begin
                if (r.clr_req) begin
                    n.st = capture_pkg::ST_ERASE;
                    n.clr_req = set_clr;
                    n.f_erase = 1'b1;
                    n.walk = 11'h000;
                    n.done = 1'b0;
                end else if (r.st == capture_pkg::ST_IDLE) begin
                    if (armed_en && !r.done) begin
                        n.st = capture_pkg::ST_ARMED;
                        n.len_e = len_sel;
                        n.pre_e = pre_sel;
                        n.ring_pos = 10'h000;
                        n.ring_full = 1'b0;
                    end
                end else if (!armed_en) begin
                    n.st = capture_pkg::ST_IDLE;
                end else if (SAMPLE_TICK && r.st == capture_pkg::ST_ARMED) begin
                    if (trig) begin
                        n.ring_start = r.ring_full ? r.ring_pos : 10'h000;
                        if (r.pre_e == r.len_e) begin
                            fin = 1'b1;
                        end else begin
                            mem_we = 1'b1;
                            mem_addr = pre_n[9:0];
                            n.count = pre_n + 11'h001;
                            n.st = capture_pkg::ST_POST;
                            fin = (pre_n + 11'h001) == len_n;
                        end
                    end else begin
                        mem_we = 1'b1;
                        mem_addr = r.ring_pos;
                        n.ring_pos = (r.ring_pos + 10'h001) & (pre_n[9:0] - 10'h001);
                        if (n.ring_pos == 10'h000) begin
                            n.ring_full = 1'b1;
                        end
                    end
                end else if (SAMPLE_TICK) begin
                    mem_we = 1'b1;
                    mem_addr = r.count[9:0];
                    n.count = r.count + 11'h001;
                    fin = (r.count + 11'h001) == len_n;
                end
            end
            capture_pkg::ST_SAVE: begin
                if (!FLASH_BUSY) begin
                    n.f_wr = 1'b1;
                    n.f_addr = r.walk;
                    n.f_wdata = {1'b0, mem2[r.walk[9:0]], 1'b0, mem1[r.walk[9:0]]};
                    if (r.walk == capture_pkg::MARKER_ADDR) begin
                        n.f_wdata = {capture_pkg::MARKER_KEY, 2'b00, r.ring_start,
                                     4'h0, r.pre_e, r.len_e};
                        n.st = capture_pkg::ST_IDLE;
                    end else begin
                        n.walk = r.walk + 11'h001;
                    end
                end
            end
            capture_pkg::ST_LOAD: begin
                if (r.pend) begin
                    n.pend = 1'b0;
                    if (r.f_addr == capture_pkg::MARKER_ADDR) begin
                        if (FLASH_RDATA[31:24] == capture_pkg::MARKER_KEY) begin
                            n.ring_start = FLASH_RDATA[21:12];
                            n.pre_e = FLASH_RDATA[7:4];
                            n.len_e = FLASH_RDATA[3:0];
                            n.done = 1'b1;
                            n.index = capture_pkg::INDEX_FIRST;
                            n.walk = 11'h000;
                        end else begin
                            n.st = capture_pkg::ST_IDLE;
                        end
                    end else begin
                        mem_we = 1'b1;
                        mem_addr = r.f_addr[9:0];
                        mem_d1 = FLASH_RDATA[14:0];
                        mem_d2 = FLASH_RDATA[30:16];
                        n.walk = r.f_addr + 11'h001;
                        if (r.f_addr == capture_pkg::WORD_LAST) begin
                            n.st = capture_pkg::ST_IDLE;
                        end
                    end
                end else if (!FLASH_BUSY) begin
                    n.f_rd = 1'b1;
                    n.f_addr = r.walk;
                    n.pend = 1'b1;
                end
            end
            capture_pkg::ST_ERASE: begin
                mem_we = 1'b1;
                mem_d1 = 15'h0000;
                mem_d2 = 15'h0000;
                if (r.walk != capture_pkg::WORD_LAST) begin
                    n.walk = r.walk + 11'h001;
                end else if (!FLASH_BUSY && !r.f_erase) begin
                    n.st = capture_pkg::ST_IDLE;
                end
            end
            default: n.st = capture_pkg::ST_IDLE;
        endcase
        if (fin) begin
            n.done = 1'b1;
            n.index = capture_pkg::INDEX_FIRST;
            n.walk = 11'h000;
            n.st = r.misc[capture_pkg::BACKUP_BIT] ? capture_pkg::ST_SAVE :
                   capture_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= '0;
            r.st <= capture_pkg::ST_LOAD;
            r.setup <= capture_pkg::SETUP_RST;
            r.alarm_ctl <= capture_pkg::ZERO_RST;
            r.thr1 <= capture_pkg::ZERO_RST;
            r.thr2 <= capture_pkg::ZERO_RST;
            r.misc <= capture_pkg::ZERO_RST;
            r.index <= capture_pkg::INDEX_FIRST;
            r.len_e <= capture_pkg::LEN_MAX;
            r.walk <= capture_pkg::MARKER_ADDR;
        end else begin
            r <= n;
        end
    end

    // sample memories carry no reset; erase clears them explicitly
    always_ff @(posedge MCLK) begin
        if (mem_we) begin
            mem1[mem_addr] <= mem_d1;
            mem2[mem_addr] <= mem_d2;
        end
    end

    assign REG_RDATA = r.rdata;
    assign REG_RVALID = r.rvalid;
    assign FLASH_ADDR = r.f_addr;
    assign FLASH_WDATA = r.f_wdata;
    assign FLASH_WR = r.f_wr;
    assign FLASH_RD = r.f_rd;
    assign FLASH_ERASE = r.f_erase;
    assign CAPTURE_DONE = r.done;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    chk_trigger_start: assert property (
        r.st == capture_pkg::ST_ARMED && n.st == capture_pkg::ST_POST |-> trig && SAMPLE_TICK)
        else $error("post phase entered without an armed alarm");
    chk_source_decode: assert property (
        mem_we && r.st == capture_pkg::ST_ARMED && r.setup[11:8] == capture_pkg::SRC_YACC
        && r.setup[15:12] == capture_pkg::SRC_XACC
        |-> mem_d1[13:0] == YACC_DATA && mem_d2[13:0] == XACC_DATA)
        else $error("recorded data does not follow source code");
    chk_flag_bit: assert property (
        mem_we && r.st == capture_pkg::ST_POST |-> mem_d1[14] == (a1 | a2))
        else $error("alarm flag bit wrong in captured word");
    chk_length_stop: assert property (
        r.st == capture_pkg::ST_POST |-> r.count < len_n && r.len_e >= capture_pkg::LEN_MIN)
        else $error("capture ran past its length");
    chk_trunc_pre: assert property (
        r.st == capture_pkg::ST_ARMED && SAMPLE_TICK && trig && !r.clr_req
        && armed_en && r.pre_e == r.len_e |=> r.done && r.st != capture_pkg::ST_POST)
        else $error("full pretrigger capture did not stop at trigger");
    chk_first_sample: assert property (
        $rose(r.done) |-> r.index == capture_pkg::INDEX_FIRST)
        else $error("finished capture does not point at first sample");
    chk_index_step: assert property (
        REG_RD && !REG_WR && {REG_ADDR[6:1], 1'b0} == capture_pkg::ADDR_READOUT_TWO
        && r.index == 11'h005 |=> r.index == 11'h006 && REG_RVALID)
        else $error("index did not advance after readout");
    chk_backup_save: assert property (
        fin && r.misc[capture_pkg::BACKUP_BIT] |=> r.st == capture_pkg::ST_SAVE ##1
        (FLASH_WR || FLASH_BUSY))
        else $error("full buffer not copied to flash");
    chk_clear_erase: assert property (
        REG_WR && REG_ADDR == capture_pkg::ADDR_COMMAND && REG_WDATA == capture_pkg::CMD_CLEAR
        && r.st == capture_pkg::ST_IDLE |-> ##2 FLASH_ERASE && r.st == capture_pkg::ST_ERASE)
        else $error("clear command did not start erase");
    chk_arm_enable: assert property (
        r.st == capture_pkg::ST_POST |-> $past(armed_en))
        else $error("capture ran with no trigger armed");

    cov_trigger: cover property (r.st == capture_pkg::ST_ARMED ##1 r.st == capture_pkg::ST_POST);
    cov_done: cover property ($rose(r.done));
    cov_save: cover property (r.st == capture_pkg::ST_SAVE ##1 r.st == capture_pkg::ST_IDLE);
    cov_restore: cover property (r.st == capture_pkg::ST_LOAD && r.done);
endmodule
`default_nettype wire

// file: design/capture_pkg.sv
// constants, register map and state type of the event capture recorder
`default_nettype none
package capture_pkg;
    // register byte offsets (16-bit registers, low byte at the even address)
    localparam logic [6:0] ADDR_THR_ONE = 7'h20;
    localparam logic [6:0] ADDR_THR_TWO = 7'h22;
    localparam logic [6:0] ADDR_READOUT_ONE = 7'h1C;
    localparam logic [6:0] ADDR_READOUT_TWO = 7'h1E;
    localparam logic [6:0] ADDR_ALARM_CTRL = 7'h28;
    localparam logic [6:0] ADDR_INDEX = 7'h2A;
    localparam logic [6:0] ADDR_MISC = 7'h34;
    localparam logic [6:0] ADDR_SETUP = 7'h38;
    localparam logic [6:0] ADDR_COMMAND = 7'h3E;
    // reset values
    localparam logic [15:0] SETUP_RST = 16'h327A;
    localparam logic [15:0] ZERO_RST = 16'h0000;
    // field positions
    localparam int SRC_TWO_LSB = 12;
    localparam int SRC_ONE_LSB = 8;
    localparam int PRE_LSB = 4;
    localparam int LEN_LSB = 0;
    localparam int TRIG_TWO_BIT = 6;
    localparam int TRIG_ONE_BIT = 4;
    localparam int BACKUP_BIT = 11;
    localparam int THR_GT_BIT = 15;
    localparam int FLAG_BIT = 14;
    // source codes; 0000 selects nothing
    localparam logic [3:0] SRC_SUPPLY = 4'h1;
    localparam logic [3:0] SRC_XACC = 4'h2;
    localparam logic [3:0] SRC_YACC = 4'h3;
    localparam logic [3:0] SRC_AUX = 4'h4;
    localparam logic [3:0] SRC_TEMP = 4'h5;
    localparam logic [3:0] SRC_RSS = 4'h8;
    // command and length limits
    localparam logic [7:0] CMD_CLEAR = 8'h03;
    localparam logic [3:0] LEN_MIN = 4'h3;
    localparam logic [3:0] LEN_MAX = 4'hA;
    localparam logic [10:0] INDEX_FIRST = 11'h001;
    localparam logic [10:0] INDEX_LAST = 11'h400;
    localparam logic [10:0] WORD_LAST = 11'h3FF;
    // flash word after the samples holds the restore marker
    localparam logic [10:0] MARKER_ADDR = 11'h400;
    localparam logic [7:0] MARKER_KEY = 8'hA5;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ARMED = 6'h02,
        ST_POST = 6'h04,
        ST_SAVE = 6'h08,
        ST_LOAD = 6'h10,
        ST_ERASE = 6'h20
    } state_type;
endpackage
`default_nettype wire

// file: design/source_mux.sv
// selects one measurement by its four-bit source code
`default_nettype none
module source_mux (
    input wire logic [3:0] code,
    input wire logic [13:0] supply,
    input wire logic [13:0] xacc,
    input wire logic [13:0] yacc,
    input wire logic [13:0] aux,
    input wire logic [13:0] temp,
    input wire logic [13:0] rss,
    output logic [13:0] data,
    output logic valid
);
    always_comb begin
        valid = 1'b1;
        case (code)
            capture_pkg::SRC_SUPPLY: data = supply;
            capture_pkg::SRC_XACC: data = xacc;
            capture_pkg::SRC_YACC: data = yacc;
            capture_pkg::SRC_AUX: data = aux;
            capture_pkg::SRC_TEMP: data = temp;
            capture_pkg::SRC_RSS: data = rss;
            default: begin
                data = 14'h0000;
                valid = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// file: design/alarm_unit.sv
// threshold compare of one alarm against its monitored measurement
`default_nettype none
module alarm_unit (
    input wire logic [13:0] data,
    input wire logic valid,
    input wire logic [15:0] threshold,
    output logic hit
);
    // codes compare as unsigned; a disabled source never alarms
    always_comb begin
        if (!valid) begin
            hit = 1'b0;
        end else if (threshold[capture_pkg::THR_GT_BIT]) begin
            hit = data > threshold[13:0];
        end else begin
            hit = data < threshold[13:0];
        end
    end
endmodule
`default_nettype wire

// file: verif/flash_model.sv
// behavioural backup flash seen from the recorder's flash port
`default_nettype none
module flash_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic [10:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic erase,
    output logic [31:0] rdata,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:1024];
    initial begin
        foreach (mem[i]) mem[i] = 32'h00000000;
    end
    assign busy = stall;
    // word shows only while the read strobe stands, its inverse otherwise,
    // so a recorder that samples late cannot pick up the right value by chance
    assign rdata = rd ? mem[addr] : ~mem[addr];
    always @(posedge clk) begin
        if (erase) begin
            foreach (mem[i]) mem[i] <= 32'h00000000;
        end else if (wr) begin
            mem[addr] <= wdata;
        end
    end
endmodule
`default_nettype wire

// file: verif/capture_recorder_tb.sv
// self-checking bench for the event capture recorder
`default_nettype none
module capture_recorder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, arst_n = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0, stall = 1'b0;
    logic [13:0] xacc = 14'h0000, yacc = 14'h0000, temp = 14'h0000;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic [15:0] rdata, got;
    logic rvalid, fwr, frd, fera, fbusy, done;
    logic [10:0] faddr;
    logic [31:0] fwdata, frdata;
    int num_errors = 0, num_checks = 0;
    always #50 mclk = ~mclk;
    capture_recorder u_dut (.MCLK(mclk), .ARST_N(arst_n), .SAMPLE_TICK(tick),
        .SUPPLY_DATA(14'h0000), .XACC_DATA(xacc), .YACC_DATA(yacc), .AUX_DATA(14'h0000),
        .TEMP_DATA(temp), .RSS_DATA(14'h0000), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .FLASH_ADDR(faddr), .FLASH_WDATA(fwdata), .FLASH_WR(fwr), .FLASH_RD(frd),
        .FLASH_ERASE(fera), .FLASH_RDATA(frdata), .FLASH_BUSY(fbusy), .CAPTURE_DONE(done));
    flash_model u_flash (.clk(mclk), .stall(stall), .addr(faddr), .wdata(fwdata), .wr(fwr),
        .rd(frd), .erase(fera), .rdata(frdata), .busy(fbusy));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] want);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check({15'h0000, rvalid}, 16'h0001);
        check(rdata, want);
    endtask
    task automatic wait_done(input logic lvl, input int limit);
        int n;
        n = 0;
        while (done !== lvl && n < limit) begin
            @(posedge mclk);
            n++;
        end
        check({15'h0000, done}, {15'h0000, lvl});
    endtask
    task automatic pulse_reset();
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
    endtask
    // two pretrigger samples are kept, so sample i is tick i+2; ticks from 4 on see the alarm
    function automatic logic [15:0] sample(input int i, input logic [13:0] base);
        return {1'b0, i >= 2, base + 14'(i + 2)};
    endfunction
    task automatic run_ticks();
        for (int t = 0; t < 10; t++) begin
            @(posedge mclk);
            xacc <= 14'h0010 + 14'(t);
            yacc <= 14'h0020 + 14'(t);
            temp <= (t >= 4) ? 14'h0200 : 14'h0010;
            tick <= 1'b1;
            @(posedge mclk);
            tick <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask
    task automatic stop_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        // whole run is about 7000 cycles
        #2000000;
        num_errors++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd_chk(capture_pkg::ADDR_SETUP, capture_pkg::SETUP_RST);
        rd_chk(capture_pkg::ADDR_INDEX, 16'h0001);
        rd_chk(7'h00, 16'h0000);
        wr_byte(capture_pkg::ADDR_SETUP, 8'h13);
        wr_byte(capture_pkg::ADDR_SETUP + 7'h01, 8'h23);
        rd_chk(capture_pkg::ADDR_SETUP, 16'h2313);
        wr_byte(capture_pkg::ADDR_THR_ONE, 8'h00);
        wr_byte(capture_pkg::ADDR_THR_ONE + 7'h01, 8'h81);
        wr_byte(capture_pkg::ADDR_MISC + 7'h01, 8'h08);
        wr_byte(capture_pkg::ADDR_ALARM_CTRL + 7'h01, 8'h05);
        wr_byte(capture_pkg::ADDR_ALARM_CTRL, 8'h50);
        run_ticks();
        wait_done(1'b1, 50);
        // stall the flash while the backup copy is under way
        stall <= 1'b1;
        repeat (20) @(posedge mclk);
        stall <= 1'b0;
        rd_chk(capture_pkg::ADDR_INDEX, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            rd_chk(capture_pkg::ADDR_READOUT_ONE, sample(i, 14'h0020));
        end
        rd_chk(capture_pkg::ADDR_INDEX, 16'h0009);
        wr_byte(capture_pkg::ADDR_INDEX, 8'h05);
        wr_byte(capture_pkg::ADDR_INDEX + 7'h01, 8'h00);
        rd_chk(capture_pkg::ADDR_INDEX, 16'h0005);
        rd_chk(capture_pkg::ADDR_READOUT_TWO, sample(4, 14'h0010));
        repeat (1200) @(posedge mclk);
        pulse_reset();
        wait_done(1'b1, 2200);
        rd_chk(capture_pkg::ADDR_READOUT_ONE, sample(0, 14'h0020));
        rd_chk(capture_pkg::ADDR_READOUT_TWO, sample(1, 14'h0010));
        wr_byte(capture_pkg::ADDR_COMMAND, capture_pkg::CMD_CLEAR);
        // the clear waits until the restore walk of about 2050 cycles is over
        wait_done(1'b0, 2200);
        repeat (1100) @(posedge mclk);
        rd_chk(capture_pkg::ADDR_READOUT_ONE, 16'h0000);
        pulse_reset();
        repeat (2200) @(posedge mclk);
        check({15'h0000, done}, 16'h0000);
        // pretrigger equal to length: the trigger ends the capture and is not stored
        wr_byte(capture_pkg::ADDR_SETUP, 8'h33);
        wr_byte(capture_pkg::ADDR_THR_ONE + 7'h01, 8'h81);
        wr_byte(capture_pkg::ADDR_ALARM_CTRL + 7'h01, 8'h05);
        wr_byte(capture_pkg::ADDR_ALARM_CTRL, 8'h57);
        run_ticks();
        wait_done(1'b1, 10);
        rd_chk(capture_pkg::ADDR_READOUT_ONE, 16'h0010);
        rd_chk(capture_pkg::ADDR_READOUT_TWO, 16'h0021);
        stop_test();
    end
endmodule
`default_nettype wire
